// ### rtl/lms_pkg.sv
`default_nettype none
package lms_pkg;
  localparam int NCH    = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ  = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 4'hC;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout matches lms_cfg_type, bit 0 upward
  localparam int CFG_W = 9;
  localparam logic [CFG_W-1:0] CTRL_RESET = 9'h000;
  localparam logic [CFG_W-1:0] CTRL_MASK  = 9'h1FF;

  // interrupt status bits
  localparam int IRQ_W       = 3;
  localparam int IRQ_LOS0    = 0;
  localparam int IRQ_LOS1    = 1;
  localparam int IRQ_REF_REJ = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET  = 3'h0;
  localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;

  // status register field positions
  localparam int ST_CFG_LSB  = 0;
  localparam int ST_REF_LSB  = 9;
  localparam int ST_LOS_LSB  = 12;
  localparam int ST_SW_BIT   = 14;
  localparam int ST_SE_BIT   = 15;

  // reference frequency codes (pin: low=00, float=10, high=11)
  localparam logic [1:0] REFCODE_LOW    = 2'h0;
  localparam logic [1:0] REFCODE_UNUSED = 2'h1;
  localparam logic [1:0] REFCODE_MID    = 2'h2;
  localparam logic [1:0] REFCODE_HIGH   = 2'h3;

  typedef enum logic [2:0] {
    LMS_REF_19M44,
    LMS_REF_77M76,
    LMS_REF_155M52,
    LMS_REF_17M408,
    LMS_REF_139M264
  } lms_ref_type;

  localparam lms_ref_type REF_RESET = LMS_REF_19M44;

  typedef struct packed {
    logic             tx_sync;
    logic [NCH-1:0]   mon;
    logic [1:0]       ref_code;
    logic             parallel;
    logic [NCH-1:0]   coax;
    logic             rate;
  } lms_cfg_type;

  typedef struct packed {
    logic        ok;
    lms_ref_type sel;
  } lms_refdec_type;

  function automatic lms_refdec_type lms_ref_decode(
    input logic       rate,
    input logic [1:0] code
  );
    lms_refdec_type r;
    r.ok  = 1'b1;
    r.sel = LMS_REF_19M44;
    unique case (code)
      REFCODE_LOW:  r.sel = rate ? LMS_REF_17M408 : LMS_REF_19M44;
      REFCODE_MID: begin
        r.sel = LMS_REF_77M76;
        r.ok  = ~rate;
      end
      REFCODE_HIGH: r.sel = rate ? LMS_REF_139M264 : LMS_REF_155M52;
      REFCODE_UNUSED: r.ok = 1'b0;
    endcase
    return r;
  endfunction : lms_ref_decode

  // 01 carries a zero, 00 and 11 carry a one; 10 is a violation, read as zero
  function automatic logic lms_cmi_decode(input logic [1:0] sym);
    return (sym == 2'h0) || (sym == 2'h3);
  endfunction : lms_cmi_decode

  function automatic logic [DATA_W-1:0] lms_strb_mask(
    input logic [DATA_W/8-1:0] strb
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W/8; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : lms_strb_mask
endpackage : lms_pkg
`default_nettype wire

// ### rtl/lms_top.sv
`default_nettype none
module lms_top
  import lms_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [DATA_W/8-1:0]   s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  serial_port_select_pin,
  input  wire logic                  line_rate_select_pin,
  input  wire logic                  media_select_pin,
  input  wire logic                  host_width_select_pin,
  input  wire logic [1:0]            refclk_freq_select,
  input  wire logic                  monitor_enable_pin,
  input  wire logic                  tx_sync_mode_pin,
  input  wire logic [NCH-1:0]        rx_los_detect,
  input  wire logic [NCH-1:0]        rx_sym_valid,
  input  wire logic [NCH-1:0][1:0]   rx_sym,
  output logic                       pdh_rate_q,
  output logic [NCH-1:0]             coax_mode_q,
  output logic                       parallel_host_q,
  output logic [NCH-1:0]             monitor_gain_q,
  output logic                       tx_retime_en_q,
  output lms_ref_type                ref_freq_sel_q,
  output logic                       refclk_single_ended_q,
  output logic [NCH-1:0]             rx_signal_loss_flag_q,
  output logic [NCH-1:0]             rx_ser_data_q,
  output logic [NCH-1:0]             rx_ser_stb_q,
  output logic [NCH-1:0][3:0]        rx_par_data_q,
  output logic [NCH-1:0]             rx_par_stb_q,
  output logic                       irq
);

  localparam int PIN_W = 8 + NCH;

  logic [PIN_W-1:0]     pin_meta_q;
  logic [PIN_W-1:0]     pin_sync_q;
  logic                 sw_mode;
  lms_cfg_type          ctrl_q;
  lms_cfg_type          pin_cfg;
  lms_cfg_type          eff_cfg;
  lms_refdec_type       ref_dec;
  logic [2:0]           ref_req_q;
  logic [NCH-1:0]       los_raw;
  logic [NCH-1:0]       mon_act;
  logic [NCH-1:0]       los_next;
  logic [NCH-1:0]       rx_bit;
  logic [NCH-1:0][2:0]  nib_q;
  logic [NCH-1:0][1:0]  cnt_q;
  logic [IRQ_W-1:0]     irq_stat_q;
  logic [IRQ_W-1:0]     irq_mask_q;
  logic [IRQ_W-1:0]     irq_evt;
  logic                 aw_hold_q;
  logic                 w_hold_q;
  logic [ADDR_W-1:0]    awaddr_q;
  logic [DATA_W-1:0]    wdata_q;
  logic [DATA_W-1:0]    wmask_q;
  logic                 do_wr;
  logic [DATA_W-1:0]    rd_word;
  logic                 rd_ok;

  // two-flop synchronisers for all straps and the analog loss detectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {rx_los_detect, tx_sync_mode_pin, monitor_enable_pin,
                     refclk_freq_select, host_width_select_pin,
                     media_select_pin, line_rate_select_pin,
                     serial_port_select_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign sw_mode  = pin_sync_q[0];
  assign los_raw  = pin_sync_q[PIN_W-1:8];

  always_comb begin
    pin_cfg.rate     = pin_sync_q[1];
    pin_cfg.coax     = {NCH{pin_sync_q[2]}};
    pin_cfg.parallel = pin_sync_q[3];
    pin_cfg.ref_code = pin_sync_q[5:4];
    pin_cfg.mon      = {NCH{pin_sync_q[6]}};
    pin_cfg.tx_sync  = pin_sync_q[7];
  end

  assign eff_cfg = sw_mode ? ctrl_q : pin_cfg;
  assign ref_dec = lms_ref_decode(eff_cfg.rate, eff_cfg.ref_code);
  assign mon_act = eff_cfg.mon & eff_cfg.coax;
  assign los_next = los_raw & ~mon_act;

  // effective mode outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pdh_rate_q      <= 1'b0;
      coax_mode_q     <= '0;
      parallel_host_q <= 1'b0;
      monitor_gain_q  <= '0;
      tx_retime_en_q  <= 1'b0;
    end else begin
      pdh_rate_q      <= eff_cfg.rate;
      coax_mode_q     <= eff_cfg.coax;
      parallel_host_q <= eff_cfg.parallel;
      monitor_gain_q  <= mon_act;
      tx_retime_en_q  <= eff_cfg.tx_sync;
    end
  end

  // reference selection keeps the last valid decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_freq_sel_q        <= REF_RESET;
      refclk_single_ended_q <= 1'b1;
      ref_req_q             <= '0;
    end else begin
      ref_req_q <= {eff_cfg.rate, eff_cfg.ref_code};
      if (ref_dec.ok) begin
        ref_freq_sel_q        <= ref_dec.sel;
        refclk_single_ended_q <= (ref_dec.sel != LMS_REF_155M52) &&
                                 (ref_dec.sel != LMS_REF_139M264);
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (rx_signal_loss_flag_q[c]) begin
        rx_bit[c] = 1'b0;
      end else if (coax_mode_q[c]) begin
        rx_bit[c] = lms_cmi_decode(rx_sym[c]);
      end else begin
        rx_bit[c] = rx_sym[c][0];
      end
    end
  end

  // receive formatting: serial bit plus strobe, or 4-bit nibbles msb first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_signal_loss_flag_q <= '0;
      rx_ser_data_q         <= '0;
      rx_ser_stb_q          <= '0;
      rx_par_data_q         <= '0;
      rx_par_stb_q          <= '0;
      nib_q                 <= '0;
      cnt_q                 <= '0;
    end else begin
      rx_signal_loss_flag_q <= los_next;
      for (int c = 0; c < NCH; c++) begin
        rx_ser_stb_q[c] <= rx_sym_valid[c] && !parallel_host_q;
        rx_par_stb_q[c] <= 1'b0;
        if (!parallel_host_q) begin
          cnt_q[c] <= 2'h0;
          if (rx_sym_valid[c]) begin
            rx_ser_data_q[c] <= rx_bit[c];
          end
        end else if (rx_sym_valid[c]) begin
          nib_q[c] <= {nib_q[c][1:0], rx_bit[c]};
          cnt_q[c] <= cnt_q[c] + 2'h1;
          if (cnt_q[c] == 2'h3) begin
            rx_par_data_q[c] <= {nib_q[c], rx_bit[c]};
            rx_par_stb_q[c]  <= 1'b1;
          end
        end
      end
    end
  end

  // interrupts: loss rising edges and a rejected reference request
  always_comb begin
    irq_evt              = '0;
    irq_evt[IRQ_LOS0]    = los_next[0] && !rx_signal_loss_flag_q[0];
    irq_evt[IRQ_LOS1]    = los_next[1] && !rx_signal_loss_flag_q[1];
    irq_evt[IRQ_REF_REJ] = !ref_dec.ok &&
                           (ref_req_q != {eff_cfg.rate, eff_cfg.ref_code});
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // axi4-lite write: address and data held apart, written once both are in
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign do_wr         = aw_hold_q && w_hold_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wmask_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wmask_q  <= lms_strb_mask(s_axi_wstrb);
      end
      if (do_wr) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_STAT ||
                         awaddr_q == ADDR_IRQ  || awaddr_q == ADDR_MASK) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= lms_cfg_type'(CTRL_RESET);
      irq_mask_q <= MASK_RESET;
      irq_stat_q <= IRQ_RESET;
    end else begin
      if (do_wr && awaddr_q == ADDR_CTRL) begin
        ctrl_q <= lms_cfg_type'((ctrl_q & ~wmask_q[CFG_W-1:0]) |
                  (wdata_q[CFG_W-1:0] & wmask_q[CFG_W-1:0] & CTRL_MASK));
      end
      if (do_wr && awaddr_q == ADDR_MASK) begin
        irq_mask_q <= (irq_mask_q & ~wmask_q[IRQ_W-1:0]) |
                      (wdata_q[IRQ_W-1:0] & wmask_q[IRQ_W-1:0]);
      end
      // a new event wins over a write-one-to-clear in the same cycle
      if (do_wr && awaddr_q == ADDR_IRQ) begin
        irq_stat_q <= (irq_stat_q &
                       ~(wdata_q[IRQ_W-1:0] & wmask_q[IRQ_W-1:0])) | irq_evt;
      end else begin
        irq_stat_q <= irq_stat_q | irq_evt;
      end
    end
  end

  // axi4-lite read: one cycle after the address is taken
  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL: rd_word[CFG_W-1:0] = ctrl_q;
      ADDR_STAT: begin
        rd_word[ST_CFG_LSB +: CFG_W] = {tx_retime_en_q, monitor_gain_q,
                                        eff_cfg.ref_code, parallel_host_q,
                                        coax_mode_q, pdh_rate_q};
        rd_word[ST_REF_LSB +: 3]     = ref_freq_sel_q;
        rd_word[ST_LOS_LSB +: NCH]   = rx_signal_loss_flag_q;
        rd_word[ST_SW_BIT]           = sw_mode;
        rd_word[ST_SE_BIT]           = refclk_single_ended_q;
      end
      ADDR_IRQ:  rd_word[IRQ_W-1:0] = irq_stat_q;
      ADDR_MASK: rd_word[IRQ_W-1:0] = irq_mask_q;
      default:   rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pin_rate_follow: assert property (
    !sw_mode |=> pdh_rate_q == $past(pin_sync_q[1]))
    else $error("rate does not follow rate strap");
  a_sw_ignore_pins: assert property (
    sw_mode ##1 sw_mode && $stable(ctrl_q) && $changed(pin_sync_q[2])
    |=> coax_mode_q == $past(coax_mode_q))
    else $error("strap change reached media in register mode");
  a_pin_media_both: assert property (
    !sw_mode |=> coax_mode_q == {NCH{$past(pin_sync_q[2])}})
    else $error("strap media not applied to both channels");
  a_ref_hold_bad: assert property (
    !ref_dec.ok |=> ref_freq_sel_q == $past(ref_freq_sel_q))
    else $error("reference changed on unsupported code");
  a_ref_high_dec: assert property (
    ref_dec.ok && eff_cfg.ref_code == REFCODE_HIGH && eff_cfg.rate
    |=> ref_freq_sel_q == LMS_REF_139M264)
    else $error("high code at pdh rate mis-decoded");
  a_mon_no_loss: assert property (
    monitor_gain_q[0] && $past(monitor_gain_q[0])
    |-> !rx_signal_loss_flag_q[0])
    else $error("loss flag raised in monitor mode");
  a_mon_coax_only: assert property (
    !coax_mode_q[1] |-> !monitor_gain_q[1])
    else $error("monitor gain outside coax mode");
  a_loss_squelch: assert property (
    rx_signal_loss_flag_q[0] && rx_sym_valid[0] && !parallel_host_q
    |=> rx_ser_stb_q[0] && !rx_ser_data_q[0])
    else $error("data not squelched or clock stopped in loss");
  a_fiber_bypass: assert property (
    rx_sym_valid[0] && !coax_mode_q[0] && !rx_signal_loss_flag_q[0]
    && !parallel_host_q |=> rx_ser_data_q[0] == $past(rx_sym[0][0]))
    else $error("fiber data altered");
  a_par_quiet_ser: assert property (
    parallel_host_q |=> !rx_ser_stb_q[0] && !rx_ser_stb_q[1])
    else $error("serial strobe in parallel mode");

  c_nibble_out: cover property (rx_par_stb_q[0] ##[1:8] rx_par_stb_q[0]);
  c_ref_reject: cover property (irq_stat_q[IRQ_REF_REJ] && irq);
  c_loss_event: cover property (!rx_signal_loss_flag_q[1]
                                ##1 rx_signal_loss_flag_q[1]);

endmodule : lms_top
`default_nettype wire

// ### sim/lms_framer_model.sv
`default_nettype none
module lms_framer_model
  import lms_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic [NCH-1:0]      ser_stb,
  input  wire logic [NCH-1:0]      ser_data,
  input  wire logic [NCH-1:0]      par_stb,
  input  wire logic [NCH-1:0][3:0] par_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NCH-1:0]   ser_q[$];
  logic [NCH*4-1:0] nib_q[$];
  // one item per strobe cycle, both lanes strobe together
  always @(posedge aclk) begin
    if (ser_stb != '0) ser_q.push_back(ser_data);
    if (par_stb != '0) nib_q.push_back(par_data);
  end
endmodule : lms_framer_model
`default_nettype wire

// ### sim/test_liu_mode_select_and_rx_format.sv
`default_nettype none
module test_liu_mode_select_and_rx_format;
  import lms_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                aclk, aresetn, irq;
  logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]   s_axi_wdata, s_axi_rdata, rv;
  logic [DATA_W/8-1:0] s_axi_wstrb;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                s_axi_rready, pdh_rate_q, parallel_host_q;
  logic [1:0]          s_axi_bresp, s_axi_rresp, refclk_freq_select, rr;
  logic                serial_port_select_pin, line_rate_select_pin;
  logic                media_select_pin, host_width_select_pin;
  logic                monitor_enable_pin, tx_sync_mode_pin;
  logic                tx_retime_en_q, refclk_single_ended_q;
  logic [NCH-1:0]      rx_los_detect, rx_sym_valid, coax_mode_q;
  logic [NCH-1:0]      monitor_gain_q, rx_signal_loss_flag_q;
  logic [NCH-1:0]      rx_ser_data_q, rx_ser_stb_q, rx_par_stb_q;
  logic [NCH-1:0]      ecoax, elos;
  logic [NCH-1:0][1:0] rx_sym;
  logic [NCH-1:0][3:0] rx_par_data_q;
  lms_ref_type         ref_freq_sel_q, ref_exp;
  logic [NCH-1:0]      eser[$];
  logic [7:0]          enib[$];
  int                  bad_count, tests_run, cycles;

  lms_top dut (.*);
  lms_framer_model fr (.aclk(aclk), .ser_stb(rx_ser_stb_q),
    .ser_data(rx_ser_data_q), .par_stb(rx_par_stb_q),
    .par_data(rx_par_data_q));

  always #50 aclk = ~aclk;

  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    tb = 1'b0;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check("bresp", rr, er);
  endtask : wr

  task automatic rdc(input string nm, input logic [3:0] a,
                     input logic [31:0] exp, input logic [1:0] er);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    tr = 1'b0;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(nm, rv, exp);
    check("rresp", rr, er);
  endtask : rdc

  function automatic lms_ref_type ref_next(logic r, logic [1:0] c,
                                           lms_ref_type p);
    case (c)
      2'h0: return r ? LMS_REF_17M408 : LMS_REF_19M44;
      2'h2: return r ? p : LMS_REF_77M76;
      2'h3: return r ? LMS_REF_139M264 : LMS_REF_155M52;
      default: return p;
    endcase
  endfunction : ref_next

  function automatic logic ebit(logic cx, logic ls, logic [1:0] s);
    if (ls) return 1'b0;
    if (cx) return s == 2'h0 || s == 2'h3;
    return s[0];
  endfunction : ebit

  task automatic cfg_chk(input lms_cfg_type c);
    logic se;
    ref_exp = ref_next(c.rate, c.ref_code, ref_exp);
    se = ref_exp inside {LMS_REF_19M44, LMS_REF_77M76, LMS_REF_17M408};
    check("rate", pdh_rate_q, c.rate);
    check("coax", coax_mode_q, c.coax);
    check("par", parallel_host_q, c.parallel);
    check("mon", monitor_gain_q, c.mon & c.coax);
    check("retime", tx_retime_en_q, c.tx_sync);
    check("ref", ref_freq_sel_q, ref_exp);
    check("se", refclk_single_ended_q, se);
  endtask : cfg_chk

  task automatic rnd_pins();
    media_select_pin      <= 1'($urandom);
    host_width_select_pin <= 1'($urandom);
    monitor_enable_pin    <= 1'($urandom);
    tx_sync_mode_pin      <= 1'($urandom);
  endtask : rnd_pins

  task automatic sym_run(input int n, input logic par);
    logic [1:0] s0, s1, b;
    logic [7:0] nb;
    nb = '0;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      s0 = 2'($urandom);
      s1 = 2'($urandom);
      rx_sym_valid <= 2'b11;
      rx_sym       <= {s1, s0};
      b  = {ebit(ecoax[1], elos[1], s1), ebit(ecoax[0], elos[0], s0)};
      nb = {nb[6:4], b[1], nb[2:0], b[0]};
      if (!par) eser.push_back(b);
      else if (i % 4 == 3) enib.push_back(nb);
    end
    @(posedge aclk);
    rx_sym_valid <= 2'b00;
  endtask : sym_run

  initial begin
    logic [31:0] d;
    aclk = 0;
    aresetn = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, rx_sym} = '0;
    {serial_port_select_pin, line_rate_select_pin, media_select_pin} = '0;
    {host_width_select_pin, monitor_enable_pin, tx_sync_mode_pin} = '0;
    {refclk_freq_select, rx_los_detect, rx_sym_valid} = '0;
    s_axi_wstrb = 4'hF;
    ref_exp = LMS_REF_19M44;
    void'($urandom(34));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    cfg_chk(9'h000);
    rdc("ctrl", ADDR_CTRL, 32'h0, RESP_OKAY);
    rdc("irqst", ADDR_IRQ, 32'h0, RESP_OKAY);
    rdc("mask", ADDR_MASK, 32'h0, RESP_OKAY);
    serial_port_select_pin <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      rnd_pins();
      line_rate_select_pin <= i[2];
      refclk_freq_select   <= i[1:0];
      repeat (5) @(posedge aclk);
      cfg_chk({tx_sync_mode_pin, {2{monitor_enable_pin}}, refclk_freq_select,
        host_width_select_pin, {2{media_select_pin}}, line_rate_select_pin});
    end
    serial_port_select_pin <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      d = 32'($urandom) & 32'h1CE;
      d = d | {26'h0, i[1:0], 3'h0, i[2]};
      rnd_pins();
      line_rate_select_pin <= 1'($urandom);
      refclk_freq_select   <= 2'($urandom);
      wr(ADDR_CTRL, d, RESP_OKAY);
      repeat (5) @(posedge aclk);
      cfg_chk(d[8:0]);
      rdc("ctrl", ADDR_CTRL, d, RESP_OKAY);
    end
    wr(ADDR_STAT, 32'h1FF, RESP_OKAY);
    wr(4'h2, 32'h1FF, RESP_SLVERR);
    rdc("ctrl", ADDR_CTRL, d, RESP_OKAY);
    rdc("unmapped", 4'h2, 32'h0, RESP_SLVERR);
    wr(ADDR_IRQ, 32'h7, RESP_OKAY);
    // coax on ch0 only, monitor asked on both, unsupported ref code
    wr(ADDR_CTRL, 32'h0D2, RESP_OKAY);
    rx_los_detect <= 2'b11;
    repeat (6) @(posedge aclk);
    cfg_chk(9'h0D2);
    check("los", rx_signal_loss_flag_q, 2'b10);
    rdc("irqst", ADDR_IRQ, 32'h6, RESP_OKAY);
    check("irq", irq, 1'b0);
    wr(ADDR_MASK, 32'h2, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq", irq, 1'b1);
    wr(ADDR_IRQ, 32'h6, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("irq", irq, 1'b0);
    wr(ADDR_CTRL, 32'h002, RESP_OKAY);
    repeat (5) @(posedge aclk);
    check("los", rx_signal_loss_flag_q, 2'b11);
    rdc("irqst", ADDR_IRQ, 32'h1, RESP_OKAY);
    check("irq", irq, 1'b0);
    rx_los_detect <= 2'b00;
    ecoax = 2'b01;
    elos  = 2'b00;
    repeat (6) @(posedge aclk);
    sym_run(12, 1'b0);
    wr(ADDR_CTRL, 32'h00A, RESP_OKAY);
    repeat (3) @(posedge aclk);
    sym_run(8, 1'b1);
    rx_los_detect <= 2'b10;
    elos = 2'b10;
    repeat (6) @(posedge aclk);
    check("los", rx_signal_loss_flag_q, 2'b10);
    sym_run(4, 1'b1);
    wr(ADDR_CTRL, 32'h002, RESP_OKAY);
    repeat (3) @(posedge aclk);
    sym_run(4, 1'b0);
    repeat (4) @(posedge aclk);
    check("nser", fr.ser_q.size(), eser.size());
    foreach (eser[k]) check("ser", fr.ser_q[k], eser[k]);
    check("nnib", fr.nib_q.size(), enib.size());
    foreach (enib[k]) check("nib", fr.nib_q[k], enib[k]);
    wrap_up();
  end
endmodule : test_liu_mode_select_and_rx_format
`default_nettype wire
